// ### tb/spi_host_model.sv
module spi_host_model (
   input wire logic clk_i,
   input wire logic sdio_i,
   output logic select_n_o,
   output logic sclk_o,
   output logic sdi_o,
   output logic sdi_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      select_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b1;
      sdi_oe_n_o = 1'b1;
   end

   // Serial clock phase of four sample clocks, changed just after an edge
   task automatic half_period;
      repeat (4) @(posedge clk_i);
      #1;
   endtask

   // ==========================================
   // Register access
   // framed host access
   task automatic access(input logic rd, input logic [3:0] addr, input logic [15:0] wdata,
                         input int nclk, output logic [15:0] rdata, output logic tail_ok);
      logic [23:0] frame;
      frame = {rd, 2'b10, addr, 1'b0, wdata};
      rdata = 16'h0000;
      tail_ok = 1'b1;
      @(posedge clk_i);
      #1;
      select_n_o = 1'b0;
      half_period();
      for (int i = 1; i <= nclk; i++) begin
         if (i <= 24 && !(rd && i > 8)) begin
            sdi_oe_n_o = 1'b0;
            sdi_o = frame[24-i];
         end
         half_period();
         sclk_o = 1'b1;
         if (rd && i > 8 && i <= 24) begin
            rdata[24-i] = sdio_i;
         end else if (rd && i > 24) begin
            tail_ok = tail_ok & (sdio_i === rdata[0]);
         end
         // Release shared line before the 8th fall
         if (rd && i == 8) begin
            sdi_oe_n_o = 1'b1;
         end
         half_period();
         sclk_o = 1'b0;
      end
      half_period();
      select_n_o = 1'b1;
      sdi_oe_n_o = 1'b1;
      half_period();
      half_period();
   endtask
endmodule

// ### tb/testbench.sv
`include "conv_ctrl_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic phase, sdr, pd1, pd2, tp, rng, mid, fall;
      logic [1:0] hiz;
      logic tpe;
      logic [15:0] range;
   } pin_row_t;

   logic clk = 1'b0, rst_b = 1'b0, mode_pin = 1'b1, phase_pin = 1'b0, sdr_pin = 1'b0, cal_pin = 1'b0;
   logic pd1_pin = 1'b0, pd2_pin = 1'b0, tp_pin = 1'b0, range_pin = 1'b0;
   logic select_n, sclk, host_d, host_oe_n, serial_data_out, sdo_oe_n, sdio;
   logic extended_control_mode, mid, fall, cal_start, tpe, tail_ok;
   logic [1:0] hiz, flush;
   logic [15:0] range1, range2, rdata;
   int errors = 0, samples_checked = 0, cal_pulses = 0, base;
   pin_row_t rows [5] = '{
      '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00, 1'b0, 16'h0000},
      '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'b00, 1'b0, 16'hFFFF},
      '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b01, 1'b0, 16'h0000},
      '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 2'b10, 1'b1, 16'hFFFF},
      '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 2'b11, 1'b0, 16'h0000}};
   logic [3:0] rd_addr [6] = '{4'h0, 4'h3, 4'hB, 4'h1, 4'hF, 4'h8};
   logic [15:0] rd_exp [6] = '{16'h0000, 16'h1234, 16'hABCD, 16'h0000, 16'h0000, 16'h0000};

   always #2 clk = ~clk;
   // Shared three-wire line with its pull-up
   assign sdio = !host_oe_n ? host_d : (!sdo_oe_n ? serial_data_out : 1'b1);
   always @(posedge clk) if (cal_start === 1'b1) cal_pulses++;

   converter_control_serial_port i_converter_control_serial_port (
      .CLK_I(clk), .RST_B_I(rst_b), .SERIAL_SELECT_N_I(select_n), .SERIAL_CLK_I(sclk),
      .SERIAL_DATA_IN_I(sdio), .SERIAL_DATA_OUT_O(serial_data_out), .SERIAL_DATA_OUT_OE_N_O(sdo_oe_n),
      .CONTROL_MODE_SELECT_PIN_I(mode_pin), .OUTPUT_PHASE_SELECT_PIN_I(phase_pin),
      .SINGLE_DATA_RATE_PIN_I(sdr_pin), .CALIBRATION_PIN_I(cal_pin), .FIRST_CHANNEL_POWER_DOWN_I(pd1_pin),
      .SECOND_CHANNEL_POWER_DOWN_I(pd2_pin), .TEST_PATTERN_SELECT_I(tp_pin), .INPUT_RANGE_SELECT_I(range_pin),
      .EXTENDED_CONTROL_MODE_O(extended_control_mode), .DDR_MID_LAUNCH_O(mid), .SDR_FALL_LAUNCH_O(fall),
      .CAL_START_O(cal_start), .CHANNEL_HIZ_O(hiz), .CHANNEL_FLUSH_O(flush), .TEST_PATTERN_ENABLE_O(tpe),
      .FIRST_CHANNEL_RANGE_O(range1), .SECOND_CHANNEL_RANGE_O(range2));

   spi_host_model i_spi_host_model (
      .clk_i(clk), .sdio_i(sdio), .select_n_o(select_n), .sclk_o(sclk), .sdi_o(host_d), .sdi_oe_n_o(host_oe_n));

   // ==========================================
   // Helpers
   task automatic check_bit(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d, input int n);
      logic [15:0] unused;
      logic unused_ok;
      i_spi_host_model.access(1'b0, a, d, n, unused, unused_ok);
   endtask

   task automatic rd(input logic [3:0] a, input int n);
      i_spi_host_model.access(1'b1, a, 16'h0000, n, rdata, tail_ok);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end

   // ==========================================
   // Main sequence
   initial begin
      cycles(8);
      check_bit("oe_n_in_reset", 1'b1, sdo_oe_n);
      check_word("range1_in_reset", 16'h0000, range1);
      cycles(8);
      rst_b = 1'b1;
      // No false power-down or flush may follow reset release
      cycles(3);
      check_word("flush_after_reset", 16'h0000, {14'h0, flush});
      foreach (rows[k]) begin
         {phase_pin, sdr_pin, pd1_pin, pd2_pin, tp_pin, range_pin} = rows[k][26:21];
         cycles(6);
         check_bit("ddr_mid", rows[k].mid, mid);
         check_bit("sdr_fall", rows[k].fall, fall);
         check_word("hiz", {14'h0, rows[k].hiz}, {14'h0, hiz});
         check_bit("test_pattern", rows[k].tpe, tpe);
         check_word("range1_pin", rows[k].range, range1);
         check_word("range2_pin", rows[k].range, range2);
      end
      {phase_pin, sdr_pin, pd1_pin, pd2_pin, tp_pin, range_pin} = 6'b000000;
      mode_pin = 1'b0;
      cycles(6);
      check_bit("extended", 1'b1, extended_control_mode);
      wr(4'h0, 16'h0000, 24);
      wr(4'h3, 16'h1234, 24);
      wr(4'hB, 16'hABCD, 24);
      cycles(6);
      check_word("range1_reg", 16'h1234, range1);
      check_word("range2_reg", 16'hABCD, range2);
      foreach (rd_addr[k]) begin
         rd(rd_addr[k], 24);
         check_word("read_back", rd_exp[k], rdata);
         check_bit("oe_n_after_read", 1'b1, sdo_oe_n);
      end
      wr(4'h0, 16'h4000, 24);
      cycles(6);
      check_bit("ddr_mid_bit", 1'b1, mid);
      wr(4'h0, 16'h4004, 24);
      cycles(6);
      check_bit("sdr_fall_bit", 1'b1, fall);
      wr(4'h0, 16'h1C00, 24);
      cycles(6);
      check_word("hiz_bits", 16'h0003, {14'h0, hiz});
      check_bit("test_pattern_bit", 1'b1, tpe);
      wr(4'h0, 16'h0000, 24);
      cycles(6);
      check_word("flush_on", 16'h0003, {14'h0, flush});
      pd2_pin = 1'b1;
      cycles(6);
      check_word("hiz_pin_or", 16'h0002, {14'h0, hiz});
      pd2_pin = 1'b0;
      cycles(80);
      check_word("flush_off", 16'h0000, {14'h0, flush});
      wr(4'h3, 16'h5555, 23);
      rd(4'h3, 24);
      check_word("aborted_write", 16'h1234, rdata);
      // Last data bit low, so a released line would read as the pull-up
      wr(4'hB, 16'h0F0E, 30);
      rd(4'hB, 30);
      check_word("long_write", 16'h0F0E, rdata);
      check_bit("long_read_hold", 1'b1, tail_ok);
      wr(4'h0, 16'h4000, 24);
      mode_pin = 1'b1;
      cycles(6);
      check_bit("pin_mode_flag", 1'b0, extended_control_mode);
      check_bit("pin_mode_phase", 1'b0, mid);
      check_word("pin_mode_range", 16'h0000, range1);
      mode_pin = 1'b0;
      cycles(6);
      rd(4'h0, 24);
      check_word("cfg_default", `CFG_DEFAULT, rdata);
      rd(4'h3, 24);
      check_word("range_default", `RANGE_DEFAULT, rdata);
      mode_pin = 1'b1;
      cycles(80);
      base = cal_pulses;
      cal_pin = 1'b1;
      cycles(40);
      check_word("cal_early", 16'h0000, 16'(cal_pulses - base));
      cycles(120);
      check_word("cal_once", 16'h0001, 16'(cal_pulses - base));
      cal_pin = 1'b0;
      cycles(10);
      cal_pin = 1'b1;
      cycles(150);
      check_word("cal_short_low", 16'h0001, 16'(cal_pulses - base));
      cal_pin = 1'b0;
      mode_pin = 1'b0;
      cycles(80);
      wr(4'h0, 16'h8000, 24);
      cycles(150);
      check_word("cal_bit", 16'h0002, 16'(cal_pulses - base));
      tally_and_finish();
   end
endmodule

// ### verilog/conv_ctrl_params.svh
`ifndef CONV_CTRL_PARAMS_SVH
`define CONV_CTRL_PARAMS_SVH
// Register addresses
`define ADDR_MAIN_CFG 4'h0
`define ADDR_RANGE_1 4'h3
`define ADDR_RANGE_2 4'hB
// Main configuration field positions
`define CFG_CAL_BIT 15
`define CFG_PHASE_BIT 14
`define CFG_TEST_BIT 12
`define CFG_PD1_BIT 11
`define CFG_PD2_BIT 10
`define CFG_SDR_BIT 2
// Reset values and range pin codes
`define CFG_DEFAULT 16'h2000
`define RANGE_DEFAULT 16'h4000
`define RANGE_LOW_CODE 16'h0000
`define RANGE_HIGH_CODE 16'hFFFF
// Serial access framing
`define ACCESS_BITS 5'h18
`define COMMAND_BITS 5'h08
// Calibration pin minimum levels, in input clock cycles
`define CAL_LOW_MIN 16'h0040
`define CAL_HIGH_MIN 16'h0040
// Cycles a channel reports flushing after leaving power-down
`define FLUSH_CYCLES 8'h40
`endif

// ### verilog/conv_ctrl_pkg.sv
package conv_ctrl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE = 3'b100
   } serial_state_t;
endpackage

// ### verilog/converter_control_serial_port.sv
// Function
// [RULE1] DDR mode: phase low launches with clock edges, high launches midway.
// [RULE2] SDR mode: phase low launches on rising edge, high on falling edge.
// [RULE3] Extended mode takes the phase from configuration bit 14.
// [RULE4] Calibration starts after pin low minimum cycles then high minimum cycles.
// [RULE5] Extended mode ORs the calibration pin with configuration bit 15.
// [RULE6] Powered-down channel floats its data pins; flush pipeline after return.
// [RULE7] Each channel powers down on its pin or its bit, 11 or 10.
// [RULE8] Test-pattern pin replaces converter data on all buses and over-range outputs.
// [RULE9] Pin mode range pin sets both channels; extended uses registers 3h, Bh.
// [RULE10] Mode pin low selects extended mode; high resets registers to defaults.
// [RULE11] Host writes every register before using extended mode.
// [RULE12] Each serial access is exactly 24 clocks, one read or write.
// [RULE13] Select low starts access; early deassertion performs nothing.
// [RULE14] Long select: read holds last bit, write commits at 24th clock.
// [RULE15] Host deasserts select after 24 clocks and between accesses.
// [RULE16] Input sampled on rising serial clock, output launched on falling.
// [RULE17] Three-wire host releases data before the 8th falling edge of reads.
// [RULE18] Output driven only in reads after 8 bits, MSB first, else floating.
// [RULE19] Reading an unmapped address returns all zeros.
// [RULE20] Host sends read/write bit then pattern 10 in bits two and three.
// [RULE21] Bits four to seven address, bit eight ignored, then 16 data bits.
`include "conv_ctrl_params.svh"
module converter_control_serial_port
   import conv_ctrl_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_B_I,
   input wire logic SERIAL_SELECT_N_I,
   input wire logic SERIAL_CLK_I,
   input wire logic SERIAL_DATA_IN_I,
   output logic SERIAL_DATA_OUT_O,
   output logic SERIAL_DATA_OUT_OE_N_O,
   input wire logic CONTROL_MODE_SELECT_PIN_I,
   input wire logic OUTPUT_PHASE_SELECT_PIN_I,
   input wire logic SINGLE_DATA_RATE_PIN_I,
   input wire logic CALIBRATION_PIN_I,
   input wire logic FIRST_CHANNEL_POWER_DOWN_I,
   input wire logic SECOND_CHANNEL_POWER_DOWN_I,
   input wire logic TEST_PATTERN_SELECT_I,
   input wire logic INPUT_RANGE_SELECT_I,
   output logic EXTENDED_CONTROL_MODE_O,
   output logic DDR_MID_LAUNCH_O,
   output logic SDR_FALL_LAUNCH_O,
   output logic CAL_START_O,
   output logic [1:0] CHANNEL_HIZ_O,
   output logic [1:0] CHANNEL_FLUSH_O,
   output logic TEST_PATTERN_ENABLE_O,
   output logic [15:0] FIRST_CHANNEL_RANGE_O,
   output logic [15:0] SECOND_CHANNEL_RANGE_O
);

   // ==========================================================
   // Input synchronisers
   logic [10:0] pin_raw;
   logic [10:0] sync1_reg;
   logic [10:0] sync2_reg;
   assign pin_raw = {INPUT_RANGE_SELECT_I, TEST_PATTERN_SELECT_I, SECOND_CHANNEL_POWER_DOWN_I,
                     FIRST_CHANNEL_POWER_DOWN_I, CALIBRATION_PIN_I, SINGLE_DATA_RATE_PIN_I,
                     OUTPUT_PHASE_SELECT_PIN_I, CONTROL_MODE_SELECT_PIN_I, SERIAL_DATA_IN_I,
                     SERIAL_CLK_I, SERIAL_SELECT_N_I};
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         // Idle pin levels, so no false edge or pulse follows reset
         sync1_reg <= 11'h00D;
         sync2_reg <= 11'h00D;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end
   logic cs_n, sclk, serial_data_in, mode_pin, phase_pin, sdr_pin, cal_pin, tp_pin, range_pin;
   logic [1:0] pd_pin;
   assign cs_n = sync2_reg[0];
   assign sclk = sync2_reg[1];
   assign serial_data_in = sync2_reg[2];
   assign mode_pin = sync2_reg[3];
   assign phase_pin = sync2_reg[4];
   assign sdr_pin = sync2_reg[5];
   assign cal_pin = sync2_reg[6];
   assign pd_pin = sync2_reg[8:7];
   assign tp_pin = sync2_reg[9];
   assign range_pin = sync2_reg[10];

   logic sclk_d_reg, cs_d_reg;
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         sclk_d_reg <= 1'b0;
         cs_d_reg <= 1'b1;
      end else begin
         sclk_d_reg <= sclk;
         cs_d_reg <= cs_n;
      end
   end
   logic sclk_rise, sclk_fall, cs_start, extended_control_mode;
   assign sclk_rise = sclk & ~sclk_d_reg;
   assign sclk_fall = ~sclk & sclk_d_reg;
   assign cs_start = ~cs_n & cs_d_reg;
   // [RULE10] Mode select
   assign extended_control_mode = ~mode_pin;

   // ==========================================================
   // Serial access engine
   function automatic logic [15:0] read_mux(input logic [3:0] a, input logic [15:0] c,
                                            input logic [15:0] r1, input logic [15:0] r2);
      case (a)
         `ADDR_MAIN_CFG: read_mux = c;
         `ADDR_RANGE_1: read_mux = r1;
         `ADDR_RANGE_2: read_mux = r2;
         // [RULE19] Unmapped reads zero
         default: read_mux = 16'h0000;
      endcase
   endfunction

   serial_state_t state_reg, state_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [15:0] in_sh_reg, in_sh_next, out_sh_reg, out_sh_next;
   logic [7:0] cmd_reg, cmd_next;
   logic sdo_reg, sdo_next, oe_n_reg, oe_n_next;
   logic [15:0] cfg_reg, cfg_next, rng1_reg, rng1_next, rng2_reg, rng2_next;
   logic [15:0] wdata;
   logic commit;
   assign wdata = {in_sh_reg[14:0], serial_data_in};

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      in_sh_next = in_sh_reg;
      out_sh_next = out_sh_reg;
      cmd_next = cmd_reg;
      sdo_next = sdo_reg;
      oe_n_next = oe_n_reg;
      commit = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // [RULE13] Select low opens an access
            if (cs_start) begin
               state_next = ST_SHIFT;
               cnt_next = 5'h00;
            end
         end
         ST_SHIFT: begin
            if (cs_n) begin
               // [RULE13] Early deassertion aborts
               state_next = ST_IDLE;
               oe_n_next = 1'b1;
            end else if (sclk_rise) begin
               // [RULE16] Sample on rising edge
               in_sh_next = wdata;
               cnt_next = cnt_reg + 5'h01;
               // [RULE21] Command byte
               if (cnt_reg == `COMMAND_BITS - 5'h01) begin
                  cmd_next = {in_sh_reg[6:0], serial_data_in};
               end
               // [RULE12] Access ends at 24th clock
               if (cnt_reg == `ACCESS_BITS - 5'h01) begin
                  state_next = ST_DONE;
                  commit = ~cmd_reg[7];
               end
            end else if (sclk_fall && cmd_reg[7] && cnt_reg >= `COMMAND_BITS) begin
               // [RULE18] Launch MSB first from 8th fall
               if (cnt_reg == `COMMAND_BITS) begin
                  {sdo_next, out_sh_next} = {read_mux(cmd_reg[4:1], cfg_reg, rng1_reg, rng2_reg), 1'b0};
                  oe_n_next = 1'b0;
               end else begin
                  {sdo_next, out_sh_next} = {out_sh_reg, 1'b0};
               end
            end
         end
         ST_DONE: begin
            // [RULE14] Hold last bit until deassertion
            if (cs_n) begin
               state_next = ST_IDLE;
               oe_n_next = 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
            oe_n_next = 1'b1;
         end
      endcase
   end

   always_comb begin
      cfg_next = cfg_reg;
      rng1_next = rng1_reg;
      rng2_next = rng2_reg;
      if (!extended_control_mode) begin
         // [RULE10] Pin mode forces defaults
         cfg_next = `CFG_DEFAULT;
         rng1_next = `RANGE_DEFAULT;
         rng2_next = `RANGE_DEFAULT;
      end else if (commit) begin
         // [RULE14] Write lands at 24th clock
         case (cmd_reg[4:1])
            `ADDR_MAIN_CFG: cfg_next = wdata;
            `ADDR_RANGE_1: rng1_next = wdata;
            `ADDR_RANGE_2: rng2_next = wdata;
            default: cfg_next = cfg_reg;
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 5'h00;
         in_sh_reg <= 16'h0000;
         out_sh_reg <= 16'h0000;
         cmd_reg <= 8'h00;
         sdo_reg <= 1'b0;
         oe_n_reg <= 1'b1;
         cfg_reg <= `CFG_DEFAULT;
         rng1_reg <= `RANGE_DEFAULT;
         rng2_reg <= `RANGE_DEFAULT;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         in_sh_reg <= in_sh_next;
         out_sh_reg <= out_sh_next;
         cmd_reg <= cmd_next;
         sdo_reg <= sdo_next;
         oe_n_reg <= oe_n_next;
         cfg_reg <= cfg_next;
         rng1_reg <= rng1_next;
         rng2_reg <= rng2_next;
      end
   end
   assign SERIAL_DATA_OUT_O = sdo_reg;
   assign SERIAL_DATA_OUT_OE_N_O = oe_n_reg;

   // ==========================================================
   // Calibration trigger
   logic [15:0] low_cnt_reg, low_cnt_next, high_cnt_reg, high_cnt_next;
   logic armed_reg, armed_next, cal_reg, cal_next, cal_lvl;
   // [RULE5] Pin ORed with configuration bit
   assign cal_lvl = cal_pin | (extended_control_mode & cfg_reg[`CFG_CAL_BIT]);
   always_comb begin
      low_cnt_next = low_cnt_reg;
      high_cnt_next = 16'h0000;
      armed_next = armed_reg;
      cal_next = 1'b0;
      if (!cal_lvl) begin
         armed_next = 1'b0;
         if (low_cnt_reg != `CAL_LOW_MIN) begin
            low_cnt_next = low_cnt_reg + 16'h0001;
         end
      end else begin
         // [RULE4] Low then high minimum
         low_cnt_next = 16'h0000;
         if (low_cnt_reg == `CAL_LOW_MIN) begin
            armed_next = 1'b1;
         end
         if (armed_reg || low_cnt_reg == `CAL_LOW_MIN) begin
            high_cnt_next = high_cnt_reg + 16'h0001;
            if (high_cnt_next == `CAL_HIGH_MIN) begin
               cal_next = 1'b1;
               armed_next = 1'b0;
            end
         end
      end
   end
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         low_cnt_reg <= 16'h0000;
         high_cnt_reg <= 16'h0000;
         armed_reg <= 1'b0;
         cal_reg <= 1'b0;
      end else begin
         low_cnt_reg <= low_cnt_next;
         high_cnt_reg <= high_cnt_next;
         armed_reg <= armed_next;
         cal_reg <= cal_next;
      end
   end
   assign CAL_START_O = cal_reg;

   // ==========================================================
   // Static controls
   logic ecm_reg, mid_reg, fall_reg, tp_reg, phase, sdr;
   logic [15:0] out_r1_reg, out_r2_reg, pin_range;
   // [RULE3] Phase source in extended mode
   assign phase = extended_control_mode ? cfg_reg[`CFG_PHASE_BIT] : phase_pin;
   assign sdr = extended_control_mode ? cfg_reg[`CFG_SDR_BIT] : sdr_pin;
   assign pin_range = range_pin ? `RANGE_HIGH_CODE : `RANGE_LOW_CODE;
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ecm_reg <= 1'b0;
         mid_reg <= 1'b0;
         fall_reg <= 1'b0;
         tp_reg <= 1'b0;
         out_r1_reg <= `RANGE_LOW_CODE;
         out_r2_reg <= `RANGE_LOW_CODE;
      end else begin
         ecm_reg <= extended_control_mode;
         // [RULE1] DDR midway launch
         mid_reg <= ~sdr & phase;
         // [RULE2] SDR falling launch
         fall_reg <= sdr & phase;
         // [RULE8] Test pattern select
         tp_reg <= tp_pin | (extended_control_mode & cfg_reg[`CFG_TEST_BIT]);
         // [RULE9] Range source
         out_r1_reg <= extended_control_mode ? rng1_reg : pin_range;
         out_r2_reg <= extended_control_mode ? rng2_reg : pin_range;
      end
   end
   assign EXTENDED_CONTROL_MODE_O = ecm_reg;
   assign DDR_MID_LAUNCH_O = mid_reg;
   assign SDR_FALL_LAUNCH_O = fall_reg;
   assign TEST_PATTERN_ENABLE_O = tp_reg;
   assign FIRST_CHANNEL_RANGE_O = out_r1_reg;
   assign SECOND_CHANNEL_RANGE_O = out_r2_reg;

   // ==========================================================
   // Per-channel power-down
   logic [1:0] pd_bit;
   assign pd_bit = {cfg_reg[`CFG_PD2_BIT], cfg_reg[`CFG_PD1_BIT]};
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic off_reg, off_next, flush_reg, flush_next;
         logic [7:0] fl_reg, fl_next;
         always_comb begin
            // [RULE7] Pin or bit powers down
            off_next = pd_pin[ch] | (extended_control_mode & pd_bit[ch]);
            fl_next = fl_reg;
            // [RULE6] Flush window after return
            if (off_next) begin
               fl_next = 8'h00;
            end else if (off_reg) begin
               fl_next = `FLUSH_CYCLES;
            end else if (fl_reg != 8'h00) begin
               fl_next = fl_reg - 8'h01;
            end
            flush_next = (fl_next != 8'h00);
         end
         always_ff @(posedge CLK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
               off_reg <= 1'b0;
               fl_reg <= 8'h00;
               flush_reg <= 1'b0;
            end else begin
               off_reg <= off_next;
               fl_reg <= fl_next;
               flush_reg <= flush_next;
            end
         end
         assign CHANNEL_HIZ_O[ch] = off_reg;
         assign CHANNEL_FLUSH_O[ch] = flush_reg;
      end
   endgenerate

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   sdo_float_idle_a: assert property (state_reg == ST_IDLE |=> oe_n_reg) // [RULE18]
      else $error("Serial output driven outside an access");
   sdo_write_off_a: assert property (!cmd_reg[7] && state_reg != ST_IDLE |-> oe_n_reg) // [RULE18]
      else $error("Serial output driven during a write");
   early_abort_a: assert property (state_reg == ST_SHIFT && cs_n |=> state_reg == ST_IDLE && oe_n_reg) // [RULE13]
      else $error("Early deassertion did not abort");
   commit_cnt_a: assert property (commit |-> cnt_reg == 5'h17 && !cs_n) // [RULE12]
      else $error("Write committed at wrong bit count");
   write_lands_a: assert property (commit && extended_control_mode && cmd_reg[4:1] == 4'h3 |=> rng1_reg == $past(wdata)) // [RULE14]
      else $error("Write data not stored");
   hold_last_a: assert property (state_reg == ST_DONE && !cs_n |=> $stable(sdo_reg)) // [RULE14]
      else $error("Last read bit not held");
   pin_defaults_a: assert property (!extended_control_mode |=> cfg_reg == `CFG_DEFAULT) // [RULE10]
      else $error("Registers not reset in pin mode");
   unmapped_zero_a: assert property (sclk_fall && state_reg == ST_SHIFT && !cs_n && cmd_reg[7]
         && cnt_reg == 5'h08 && cmd_reg[4:1] == 4'h1 |=> !sdo_reg && out_sh_reg == 16'h0000) // [RULE19]
      else $error("Unmapped read not zero");
   cal_or_a: assert property (cal_reg |-> $past(cal_lvl, 1)) // [RULE5]
      else $error("Calibration started with level low");
   pd_hiz_a: assert property (pd_pin[0] |=> CHANNEL_HIZ_O[0]) // [RULE6]
      else $error("Powered-down channel not floating");
   phase_sel_a: assert property (extended_control_mode && !sdr |=> DDR_MID_LAUNCH_O == $past(cfg_reg[`CFG_PHASE_BIT])) // [RULE3]
      else $error("Phase not taken from register");
   read_cov_c: cover property (state_reg == ST_DONE && cmd_reg[7] && !oe_n_reg);
   write_cov_c: cover property (commit && extended_control_mode);
   cal_cov_c: cover property (cal_reg);
   abort_cov_c: cover property (state_reg == ST_SHIFT && cs_n);
endmodule
